// *** hw/fdr_params.svh ***
// Purpose: constants for the divide, round and float-format slice
// Assumes: included by bare name from the divider, the top and the bench
// Notes: register offsets are byte addresses on the slave port
`ifndef FDR_PARAMS_SVH
`define FDR_PARAMS_SVH

// ==========================================================
// register map (byte addresses)
`define FDR_OFF_CMD 5'h00
`define FDR_OFF_EVEN 5'h04
`define FDR_OFF_ODD 5'h08
`define FDR_OFF_SRC 5'h0C
`define FDR_OFF_INSTR 5'h10
`define FDR_OFF_STATUS 5'h14
`define FDR_OFF_DECODE 5'h18
`define FDR_OFF_EXP 5'h1C

// ==========================================================
// command register fields
`define FDR_CMD_OP 2:0
`define FDR_CMD_DBL 3
`define FDR_CMD_UFL 4
`define FDR_CMD_OFL 5

// ==========================================================
// condition flag positions inside the 4-bit flag word
`define FDR_CC_EXC 3
`define FDR_CC_POS 2
`define FDR_CC_NEG 1
`define FDR_CC_ZERO 0
`define FDR_CC_EXC_ONLY 4'h8

// ==========================================================
// instruction word fields (bit 0 of the manual is bit 31 here)
`define FDR_IW_OPC 31:26
`define FDR_IW_REG 25:23
`define FDR_IW_IDX 22:21
`define FDR_IW_IND 20
`define FDR_IW_AUG 19
`define FDR_IW_IMM 15:0
`define FDR_IW_IMM_SIGN 15

// ==========================================================
// float word fields and exponent bias
`define FDR_FP_SIGN 31
`define FDR_FP_EXP 30:24
`define FDR_FP_FRAC 23:0
`define FDR_FP_TOP_DIGIT 23:20
`define FDR_FP_LOW_DIGITS 19:0
`define FDR_FP_MINUS_ONE_FRAC 24'hF0_0000
`define FDR_EXP_BIAS 8'h40
`define FDR_FP_NORM_SHIFTS 6

// ==========================================================
// integer limits and status bits
`define FDR_INT_MAX 32'h7FFF_FFFF
`define FDR_INT_MIN_MAG 32'h8000_0000
`define FDR_STAT_BUSY 4

`endif

// *** hw/fdr_pkg.sv ***
// Purpose: shared types for the divide, round and float-format slice
// Assumes: nothing
// Notes: operation codes follow the order of the enum
package fdr_pkg;

  // ==========================================================
  // operation selected by the command register
  typedef enum logic [2:0] {
    op_div_reg,
    op_div_imm,
    op_sign_fill,
    op_round_pair,
    op_fp_class,
    op_fp_negate,
    op_fp_norm
  } fdr_op_t;

  // ==========================================================
  // sequencing of the multi-cycle divide
  typedef enum logic [1:0] {
    st_idle,
    st_run,
    st_finish
  } fdr_state_t;

endpackage : fdr_pkg

// *** hw/fdr_div_if.sv ***
// Purpose: carrier between the control block and the divide array
// Assumes: one clock shared by both ends
// Notes: magnitudes only; signs are handled by the control block
`timescale 1ns/1ps

interface fdr_div_if;
  logic start;
  logic [63:0] dividend;
  logic [31:0] divisor;
  logic done;
  logic [31:0] quotient;
  logic [31:0] remainder;

  // control side launches and collects
  modport ctrl (
    output start,
    output dividend,
    output divisor,
    input done,
    input quotient,
    input remainder
  );

  // array side computes
  modport unit (
    input start,
    input dividend,
    input divisor,
    output done,
    output quotient,
    output remainder
  );
endinterface : fdr_div_if

// *** hw/fdr_divider.sv ***
// Purpose: unsigned restoring divide, one quotient bit per clock
// Assumes: high half of dividend is below divisor at start
// Notes: done pulses high on the same edge that stores the last step
`timescale 1ns/1ps
`include "fdr_params.svh"

module fdr_divider import fdr_pkg::*; #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // divide carrier
  fdr_div_if.unit div_if
);
  localparam int CW = $clog2(W) + 1;
  localparam logic [CW-1:0] LAST_STEP = CW'(W - 1);

  logic [W-1:0] rem_reg;
  logic [W-1:0] quo_reg;
  logic [W-1:0] dvs_reg;
  logic [CW-1:0] cnt_reg;
  logic run_reg;
  logic done_reg;
  logic [W:0] trial;
  logic take;

  // ==========================================================
  // one restoring step
  always_comb begin
    trial = {rem_reg, quo_reg[W-1]};
    take = (trial >= {1'b0, dvs_reg});
  end

  // shift-subtract array
  always_ff @(posedge ref_clk_in) begin
    if (div_if.start) begin
      rem_reg <= div_if.dividend[2*W-1:W];
      quo_reg <= div_if.dividend[W-1:0];
      dvs_reg <= div_if.divisor;
    end else if (run_reg) begin
      rem_reg <= take ? W'(trial - {1'b0, dvs_reg}) : trial[W-1:0];
      quo_reg <= {quo_reg[W-2:0], take};
    end
  end

  // step counter and completion pulse
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (div_if.start) begin
      cnt_reg <= '0;
      run_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= run_reg && (cnt_reg == LAST_STEP);
      if (run_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == LAST_STEP) begin
          run_reg <= 1'b0;
        end
      end
    end
  end

  assign div_if.done = done_reg;
  assign div_if.quotient = quo_reg;
  assign div_if.remainder = rem_reg;
endmodule : fdr_divider

// *** hw/fdr_top.sv ***
// Purpose: fixed divide, sign fill, round and float-format datapath slice
// Assumes: Avalon-MM slave, one clock, synchronous active-high reset
// Notes: a command write launches the selected operation
// Function
// - register divide: pair dividend over source word, quotient odd, remainder even
// - remainder takes the sign of the original dividend
// - quotient sign is product of signs; small dividend gives zero quotient
// - quotient beyond 32 bits flags exception and keeps dividend in pair
// - divide flags: exception, else one of positive, negative, zero
// - immediate divide uses sign-extended low halfword of instruction as divisor
// - sign fill copies odd register sign into all even bits
// - round adds one when next register top bit set; overflow flags exception
// - float instruction fields: opcode, register, index, indirect, address
// - address bit 12 of float instruction is the augment variant bit
// - every float operation sets sign or zero flags and exceptions; negate here never sets exception
// - exponent fault sets exception, overflow adds fourth flag, sign shown
// - float flag encodings for exception, sign, zero, underflow, overflow
// - float word: sign top bit, 7-bit exponent, hex fraction below
// - doubleword float extends fraction by eight hex digits in second word
// - exponent stored with bias of 40 hex for unsigned comparison
// - value is fraction times sixteen to exponent minus bias
// - results normalized to one-sixteenth or more; minus one rewritten legally
// - negation: two's complement fraction, one's complement exponent
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "fdr_params.svh"

module fdr_top import fdr_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // sequencer side
  output logic done_out,
  output logic [3:0] cond_flags_out
);
  fdr_div_if div_if ();

  fdr_state_t state_reg;
  logic bus_ack_reg;
  logic [31:0] readdata_reg;
  logic [5:0] cmd_reg;
  logic [31:0] even_reg;
  logic [31:0] odd_reg;
  logic [31:0] src_reg;
  logic [31:0] instr_reg;
  logic [3:0] flags_reg;
  logic done_reg;
  logic exc_reg;
  logic neg_q_reg;
  logic neg_r_reg;
  logic req;
  logic wr_stall;
  logic wr_take;
  logic launch;
  fdr_op_t launch_op;
  logic is_div;
  logic [31:0] rd_mux;
  logic [31:0] div_divisor;
  logic [63:0] dvd_mag;
  logic [31:0] dvs_mag;
  logic pre_exc;
  logic fin_exc;
  logic [31:0] q_val;
  logic [31:0] r_val;
  logic [31:0] op_even;
  logic [31:0] op_odd;
  logic [3:0] op_flags;
  logic [32:0] fp_n;
  logic [63:0] fp_x;
  logic [6:0] exp_true;
  logic [7:0] exp_unb;

  // ==========================================================
  // helpers
  // flags for a signed integer result
  function automatic logic [3:0] cc_int(input logic [31:0] x);
    cc_int = {1'b0, ~x[31] & (|x), x[31], ~(|x)};
  endfunction : cc_int

  // flags for a float result, with optional exponent fault
  function automatic logic [3:0] fp_cc(input logic [31:0] w, input logic [31:0] lo,
                                       input logic dbl, input logic ufl, input logic ofl);
    logic z;
    z = ~w[`FDR_FP_SIGN] && (w[`FDR_FP_FRAC] == '0) && (!dbl || lo == '0);
    if (ufl || ofl) begin
      fp_cc = {1'b1, ~w[`FDR_FP_SIGN], w[`FDR_FP_SIGN], ofl};
    end else begin
      fp_cc = {1'b0, ~w[`FDR_FP_SIGN] & ~z, w[`FDR_FP_SIGN], z};
    end
  endfunction : fp_cc

  // negate: two's complement fraction, one's complement exponent
  function automatic logic [63:0] fp_neg(input logic [31:0] w, input logic [31:0] lo,
                                         input logic dbl);
    logic [56:0] m;
    logic [24:0] s;
    m = -{w[`FDR_FP_SIGN], w[`FDR_FP_FRAC], lo};
    s = -{w[`FDR_FP_SIGN], w[`FDR_FP_FRAC]};
    if (dbl) begin
      fp_neg = {m[56], ~w[`FDR_FP_EXP], m[55:32], m[31:0]};
    end else begin
      fp_neg = {s[24], ~w[`FDR_FP_EXP], s[23:0], lo};
    end
  endfunction : fp_neg

  // normalize a float word; top bit returned is exponent underflow
  function automatic logic [32:0] fp_norm(input logic [31:0] w);
    logic [31:0] m;
    logic [6:0] e;
    logic [23:0] f;
    logic uf;
    m = w[`FDR_FP_SIGN] ? -w : w;
    e = m[`FDR_FP_EXP];
    f = m[`FDR_FP_FRAC];
    uf = 1'b0;
    for (int i = 0; i < `FDR_FP_NORM_SHIFTS; i++) begin
      if (f != '0 && f[`FDR_FP_TOP_DIGIT] == 4'h0) begin
        uf = uf | (e == 7'h00);
        e = e - 7'h01;
        f = {f[`FDR_FP_LOW_DIGITS], 4'h0};
      end
    end
    if (w[`FDR_FP_SIGN] && w[`FDR_FP_FRAC] == '0) begin
      // minus one rewritten as a legal form
      fp_norm = {1'b0, 1'b1, w[`FDR_FP_EXP] - 7'h01, `FDR_FP_MINUS_ONE_FRAC};
    end else if (f == '0) begin
      fp_norm = '0;
    end else begin
      m = {1'b0, e, f};
      fp_norm = {uf, w[`FDR_FP_SIGN] ? -m : m};
    end
  endfunction : fp_norm

  // byte-lane merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      be_merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : be_merge

  // ==========================================================
  // bus handshake: one wait state, writes stall while dividing
  assign req = avs_read_in | avs_write_in;
  assign wr_stall = avs_write_in && (state_reg != st_idle);
  assign avs_waitrequest_out = req & ~bus_ack_reg;
  assign wr_take = avs_write_in & bus_ack_reg;
  assign launch = wr_take && (avs_address_in == `FDR_OFF_CMD);
  assign launch_op = fdr_op_t'(avs_writedata_in[`FDR_CMD_OP]);
  assign is_div = (launch_op == op_div_reg) || (launch_op == op_div_imm);

  // acknowledge and read data capture
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bus_ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      bus_ack_reg <= req & ~bus_ack_reg & ~wr_stall;
      if (avs_read_in && !bus_ack_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end
  assign avs_readdata_out = readdata_reg;

  // unbiased exponent of the even register
  assign exp_true = even_reg[`FDR_FP_SIGN] ? ~even_reg[`FDR_FP_EXP] : even_reg[`FDR_FP_EXP];
  assign exp_unb = {1'b0, exp_true} - `FDR_EXP_BIAS;

  // read mux; unmapped addresses read zero
  always_comb begin
    case (avs_address_in)
      `FDR_OFF_CMD: rd_mux = {26'h000_0000, cmd_reg};
      `FDR_OFF_EVEN: rd_mux = even_reg;
      `FDR_OFF_ODD: rd_mux = odd_reg;
      `FDR_OFF_SRC: rd_mux = src_reg;
      `FDR_OFF_INSTR: rd_mux = instr_reg;
      `FDR_OFF_STATUS: rd_mux = {27'h000_0000, state_reg != st_idle, flags_reg};
      `FDR_OFF_DECODE: rd_mux = {19'h0_0000, instr_reg[`FDR_IW_OPC], instr_reg[`FDR_IW_REG],
                                 instr_reg[`FDR_IW_IDX], instr_reg[`FDR_IW_IND],
                                 instr_reg[`FDR_IW_AUG]};
      `FDR_OFF_EXP: rd_mux = {{24{exp_unb[7]}}, exp_unb};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // divide launch: divisor select, magnitudes, early exception
  always_comb begin
    if (launch_op == op_div_imm) begin
      div_divisor = {{16{instr_reg[`FDR_IW_IMM_SIGN]}}, instr_reg[`FDR_IW_IMM]};
    end else begin
      div_divisor = src_reg;
    end
    dvd_mag = even_reg[31] ? -{even_reg, odd_reg} : {even_reg, odd_reg};
    dvs_mag = div_divisor[31] ? -div_divisor : div_divisor;
    pre_exc = (dvs_mag == 32'h0000_0000) || (dvd_mag[63:32] >= dvs_mag);
  end
  assign div_if.start = launch && is_div && !pre_exc;
  assign div_if.dividend = dvd_mag;
  assign div_if.divisor = dvs_mag;

  // finish: apply signs and the 32-bit range check
  always_comb begin
    if (neg_q_reg) begin
      fin_exc = exc_reg || (div_if.quotient > `FDR_INT_MIN_MAG);
    end else begin
      fin_exc = exc_reg || div_if.quotient[31];
    end
    q_val = neg_q_reg ? -div_if.quotient : div_if.quotient;
    r_val = neg_r_reg ? -div_if.remainder : div_if.remainder;
  end

  // sequencing and saved signs
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= st_idle;
      cmd_reg <= 6'h00;
      exc_reg <= 1'b0;
      neg_q_reg <= 1'b0;
      neg_r_reg <= 1'b0;
    end else begin
      case (state_reg)
        st_idle: begin
          if (launch) begin
            cmd_reg <= avs_writedata_in[5:0];
            if (is_div) begin
              exc_reg <= pre_exc;
              neg_q_reg <= even_reg[31] ^ div_divisor[31];
              neg_r_reg <= even_reg[31];
              state_reg <= pre_exc ? st_finish : st_run;
            end
          end
        end
        st_run: begin
          if (div_if.done) begin
            state_reg <= st_finish;
          end
        end
        st_finish: state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // single-cycle operations
  always_comb begin
    fp_n = fp_norm(even_reg);
    fp_x = fp_neg(even_reg, odd_reg, avs_writedata_in[`FDR_CMD_DBL]);
    op_even = even_reg;
    op_odd = odd_reg;
    op_flags = flags_reg;
    case (launch_op)
      op_sign_fill: begin
        op_even = {32{odd_reg[31]}};
        op_flags = cc_int(op_even);
      end
      op_round_pair: begin
        if (odd_reg[31]) begin
          op_even = even_reg + 32'h0000_0001;
        end
        if (odd_reg[31] && even_reg == `FDR_INT_MAX) begin
          op_flags = `FDR_CC_EXC_ONLY;
        end else begin
          op_flags = cc_int(op_even);
        end
      end
      op_fp_class: begin
        op_flags = fp_cc(even_reg, odd_reg, avs_writedata_in[`FDR_CMD_DBL],
                         avs_writedata_in[`FDR_CMD_UFL],
                         avs_writedata_in[`FDR_CMD_OFL]);
      end
      op_fp_negate: begin
        op_even = fp_x[63:32];
        op_odd = fp_x[31:0];
        op_flags = fp_cc(op_even, op_odd, avs_writedata_in[`FDR_CMD_DBL],
                         1'b0, 1'b0);
      end
      op_fp_norm: begin
        op_even = fp_n[31:0];
        op_flags = fp_cc(op_even, odd_reg, 1'b0, fp_n[32], 1'b0);
      end
      default: begin
      end
    endcase
  end

  // ==========================================================
  // register pair: bus writes, single-cycle results, divide results
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      even_reg <= 32'h0000_0000;
      odd_reg <= 32'h0000_0000;
    end else if (state_reg == st_finish) begin
      if (!fin_exc) begin
        even_reg <= r_val;
        odd_reg <= q_val;
      end
    end else if (launch && !is_div) begin
      even_reg <= op_even;
      odd_reg <= op_odd;
    end else if (wr_take && avs_address_in == `FDR_OFF_EVEN) begin
      even_reg <= be_merge(even_reg, avs_writedata_in, avs_byteenable_in);
    end else if (wr_take && avs_address_in == `FDR_OFF_ODD) begin
      odd_reg <= be_merge(odd_reg, avs_writedata_in, avs_byteenable_in);
    end
  end

  // source word and instruction word
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      src_reg <= 32'h0000_0000;
      instr_reg <= 32'h0000_0000;
    end else if (wr_take && avs_address_in == `FDR_OFF_SRC) begin
      src_reg <= be_merge(src_reg, avs_writedata_in, avs_byteenable_in);
    end else if (wr_take && avs_address_in == `FDR_OFF_INSTR) begin
      instr_reg <= be_merge(instr_reg, avs_writedata_in, avs_byteenable_in);
    end
  end

  // condition flags and done pulse
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_reg <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == st_finish) || (launch && !is_div && launch_op != 3'h7);
      if (state_reg == st_finish) begin
        flags_reg <= fin_exc ? `FDR_CC_EXC_ONLY : cc_int(q_val);
      end else if (launch && !is_div) begin
        flags_reg <= op_flags;
      end
    end
  end
  assign done_out = done_reg;
  assign cond_flags_out = flags_reg;

  fdr_divider #(
    .W(32)
  ) u_divider (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .div_if(div_if)
  );

  // ==========================================================
  // assertions
  bus_one_wait_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (avs_read_in && !bus_ack_reg) |=> !avs_waitrequest_out)
    else $error("read not answered after one wait state");
  fill_result_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (launch && launch_op == op_sign_fill) |=>
      (even_reg == {32{$past(odd_reg[31])}}) && !flags_reg[`FDR_CC_EXC])
    else $error("sign fill result wrong");
  round_inc_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (launch && launch_op == op_round_pair && odd_reg[31] && even_reg != `FDR_INT_MAX) |=>
      even_reg == $past(even_reg) + 32'h0000_0001)
    else $error("round did not add one");
  rem_sign_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == st_finish && !fin_exc && r_val != '0) |=> even_reg[31] == $past(neg_r_reg))
    else $error("remainder sign differs from dividend");
  exc_restore_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == st_finish && fin_exc) |=>
      $stable(even_reg) && $stable(odd_reg) && flags_reg == `FDR_CC_EXC_ONLY)
    else $error("dividend not kept on exception");
  div_flags_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ($past(state_reg) == st_finish && !flags_reg[`FDR_CC_EXC]) |-> $onehot(flags_reg))
    else $error("divide flags not one-hot");
  div_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == st_run) |=> $stable(even_reg) && $stable(odd_reg))
    else $error("pair changed during divide");
  done_pulse_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_reg == st_finish) |=> done_out ##1 !done_out)
    else $error("done not a single pulse");
  fp_ovf_flags_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (launch && launch_op == op_fp_class && avs_writedata_in[`FDR_CMD_OFL]) |=>
      flags_reg[`FDR_CC_EXC] && flags_reg[`FDR_CC_ZERO] &&
      (flags_reg[`FDR_CC_POS] != flags_reg[`FDR_CC_NEG]))
    else $error("overflow flags wrong");
endmodule : fdr_top

// *** tb/fdr_seq_model.sv ***
// Purpose: sequencer model that collects completions and flags
// Assumes: done is a one-cycle pulse, flags valid while it is high
// Notes: the bench names the even/odd pair, the source, the instruction word and the decode and exponent views
`timescale 1ns/1ps

module fdr_seq_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // block outputs
  input wire logic done_in,
  input wire logic [3:0] flags_in,
  // collected results
  output logic [3:0] flags_out,
  output logic [7:0] dones_out
);
  // ==========================================================
  // latch flags with each completion and count the completions
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_out <= 4'h0;
      dones_out <= 8'h00;
    end else if (done_in) begin
      flags_out <= flags_in;
      dones_out <= dones_out + 8'h01;
    end
  end
endmodule : fdr_seq_model

// *** tb/fdr_top_tb.sv ***
// Purpose: self-checking bench for the divide, round and float slice
// Assumes: avalon-mm master tasks, single clock
// Notes: every scenario is its own task
`timescale 1ns/1ps
`include "fdr_params.svh"

module fdr_top_tb import fdr_pkg::*; ;
  // ==========================================================
  // stimulus and observation
  localparam logic [31:0] zw = 32'h0000_0000;
  localparam logic [31:0] pw = 32'h4210_0000;
  localparam logic [31:0] nw = 32'hBDF0_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdo;
  logic [31:0] rv;
  logic wreq;
  logic done;
  logic [3:0] fl;
  logic [3:0] mfl;
  logic [7:0] mdn;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;

  // free-running clock
  initial begin
    forever #5 clk = ~clk;
  end

  // design and sequencer model
  fdr_top dut_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(4'hF), .avs_writedata_in(wd),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq), .done_out(done),
    .cond_flags_out(fl)
  );
  fdr_seq_model seq_u (
    .ref_clk_in(clk), .sys_rst_in(rst), .done_in(done), .flags_in(fl),
    .flags_out(mfl), .dones_out(mdn)
  );

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    rv = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  // load pair and divisor, launch, wait for done, judge pair and flags
  task automatic op(input logic [7:0] c, input logic [31:0] e, o, s, xe, xo,
                    input logic [3:0] f);
    int n;
    logic [7:0] d0;
    n = 0;
    d0 = mdn;
    bus(1'b1, `FDR_OFF_EVEN, e);
    bus(1'b1, `FDR_OFF_ODD, o);
    bus(1'b1, `FDR_OFF_SRC, s);
    bus(1'b1, `FDR_OFF_CMD, {24'h00_0000, c});
    @(negedge clk);
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    bus(1'b0, `FDR_OFF_EVEN, zw);
    check(rv, xe);
    bus(1'b0, `FDR_OFF_ODD, zw);
    check(rv, xo);
    check({28'h000_0000, mfl}, {28'h000_0000, f});
    check({24'h00_0000, mdn}, {24'h00_0000, d0 + 8'h01});
  endtask : op

  // ==========================================================
  // scenarios
  task automatic t_div();
    op(8'h00, zw, 32'h0000_00FF, 32'h0000_000A, 32'h0000_0005, 32'h0000_0019, 4'h4);
    op(8'h00, zw, 32'h0000_0003, 32'hFFFF_FFFB, 32'h0000_0003, zw, 4'h1);
    op(8'h00, 32'h0000_0001, zw, 32'h0000_0001, 32'h0000_0001, zw, 4'h8);
    $display("test register divide finished");
  endtask : t_div

  task automatic t_imm();
    bus(1'b1, `FDR_OFF_INSTR, 32'h0000_0002);
    op(8'h01, 32'hFFFF_FFFF, 32'hFFFF_FFF9, zw, 32'hFFFF_FFFF, 32'hFFFF_FFFD, 4'h2);
    bus(1'b1, `FDR_OFF_INSTR, 32'h0000_FFFE);
    op(8'h01, zw, 32'h0000_0007, zw, 32'h0000_0001, 32'hFFFF_FFFD, 4'h2);
    $display("test immediate divide finished");
  endtask : t_imm

  task automatic t_fill();
    op(8'h02, zw, 32'h8000_0000, zw, 32'hFFFF_FFFF, 32'h8000_0000, 4'h2);
    op(8'h02, 32'hFFFF_FFFF, 32'h7FFF_FFFF, zw, zw, 32'h7FFF_FFFF, 4'h1);
    op(8'h03, 32'h0000_0005, 32'h8000_0000, zw, 32'h0000_0006, 32'h8000_0000, 4'h4);
    op(8'h03, 32'h7FFF_FFFF, 32'h8000_0000, zw, 32'h8000_0000, 32'h8000_0000, 4'h8);
    op(8'h03, 32'h0000_0005, 32'h7FFF_FFFF, zw, 32'h0000_0005, 32'h7FFF_FFFF, 4'h4);
    $display("test sign fill and round finished");
  endtask : t_fill

  task automatic t_dec();
    bus(1'b1, `FDR_OFF_INSTR, {6'h38, 3'h5, 2'h2, 1'b1, 1'b1, 19'h0_0000});
    bus(1'b0, `FDR_OFF_DECODE, zw);
    check(rv, 32'h0000_1C5B);
    bus(1'b1, `FDR_OFF_INSTR, {6'h07, 3'h2, 2'h1, 1'b0, 1'b0, 19'h0_0000});
    bus(1'b0, `FDR_OFF_DECODE, zw);
    check(rv, 32'h0000_03A4);
    $display("test float decode finished");
  endtask : t_dec

  task automatic t_fp();
    logic [31:0] w [7];
    logic [7:0] c [7];
    logic [3:0] f [7];
    w = '{pw, nw, zw, pw, nw, pw, nw};
    c = '{8'h04, 8'h04, 8'h04, 8'h14, 8'h14, 8'h34, 8'h24};
    f = '{4'h4, 4'h2, 4'h1, 4'hC, 4'hA, 4'hD, 4'hB};
    for (int i = 0; i < 7; i++) begin
      op(c[i], w[i], zw, zw, w[i], zw, f[i]);
    end
    bus(1'b0, `FDR_OFF_EXP, zw);
    check(rv, 32'h0000_0002);
    op(8'h05, pw, zw, zw, nw, zw, 4'h2);
    op(8'h0D, pw, 32'h0000_0001, zw, 32'hBDEF_FFFF, 32'hFFFF_FFFF, 4'h2);
    op(8'h06, 32'h4301_0000, zw, zw, 32'h4210_0000, zw, 4'h4);
    op(8'h06, 32'hC100_0000, zw, zw, 32'hC0F0_0000, zw, 4'h2);
    $display("test float format finished");
  endtask : t_fp

  // ==========================================================
  // verdict
  task automatic close_out();
    $display("mismatches %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_div();
    t_imm();
    t_fill();
    t_dec();
    t_fp();
    close_out();
  end
endmodule : fdr_top_tb
